// >>> inc/dps_consts.svh
// constants for the digital page store host
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
`define DPS_SLAVE_WR          8'h80
`define DPS_SLAVE_RD          8'h81
`define DPS_OPC_ENTER         8'hc0
`define DPS_OPC_EXIT          8'h40
`define DPS_PAGE_ERASE_OPCODE 8'hd1
`define DPS_OPC_WRITE         8'hc9
`define DPS_OPC_READ          8'he1
`define DPS_OPC_HALT          8'hc0
`define DPS_NONE              8'h00
`define DPS_BIT_ACK           4'h8
`define DPS_LAST_BYTE         12'h007
`define DPS_STEP_ENTER        5'h02
`define DPS_STEP_BODY         5'h04
`define DPS_STEP_LO           5'h08
`define DPS_STEP_CNT          5'h0a
`define DPS_STEP_HALT         5'h0b
`define DPS_TAIL_ERASE        5'h10
`define DPS_TAIL_WRITE        5'h0b
`define DPS_TAIL_READ         5'h0d
`define DPS_CLK_MHZ           200
`define DPS_T_QTR_NS          250 // 1 us bit; a slow device stretches scl
`define DPS_QTR_CYC ((`DPS_T_QTR_NS * `DPS_CLK_MHZ + 999) / 1000)
`define DPS_QTR_W             8
`endif

// >>> inc/dps_pkg.sv
// types shared by the digital page store host
`default_nettype none
package dps_pkg;
  typedef enum logic [1:0] {
    DPS_OP_ERASE = 2'h0,
    DPS_OP_WRITE = 2'h1,
    DPS_OP_READ  = 2'h2
  } dps_op_e;
  typedef enum logic [2:0] {
    DPS_K_START = 3'h0,
    DPS_K_SEND  = 3'h1,
    DPS_K_DATA  = 3'h2,
    DPS_K_READ  = 3'h3,
    DPS_K_STOP  = 3'h4,
    DPS_K_STRB  = 3'h5,
    DPS_K_END   = 3'h6
  } dps_kind_e;
  typedef enum logic [4:0] {
    DPS_ST_IDLE    = 5'h01,
    DPS_ST_FETCH   = 5'h02,
    DPS_ST_RUN     = 5'h04,
    DPS_ST_STRB_LO = 5'h08,
    DPS_ST_STRB_HI = 5'h10
  } dps_st_e;
  typedef struct packed {
    logic [10:0] page;
    logic [4:0]  block;
  } dps_addr_s;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } dps_wire_addr_s;
  typedef struct packed {
    dps_op_e     op;
    dps_addr_s   addr;
    logic [11:0] rows;
  } dps_cmd_s;
  typedef struct packed {
    logic err;
    logic ovf;
  } dps_rsp_s;
  typedef struct packed {
    dps_kind_e  kind;
    logic [7:0] val;
  } dps_item_s;
endpackage
`default_nettype wire

// >>> hdl/dps_host.sv
// digital page store host: i2c master running erase, write, read
`timescale 1ns/1ps
`default_nettype none
`include "dps_consts.svh"
module dps_host (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           cmd_valid,
  output logic                cmd_ready,
  input  wire dps_pkg::dps_cmd_s cmd,
  input  wire logic           wr_valid,
  output logic                wr_ready,
  input  wire logic [7:0]     wr_data,
  output logic                rd_valid,
  output logic [7:0]          rd_data,
  output logic                rd_last,
  output logic                done,
  output dps_pkg::dps_rsp_s   rsp,
  output logic                busy,
  output logic                overflow_flag,
  input  wire logic           scl_i,
  output logic                scl_o,
  output logic                scl_oe,
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe,
  input  wire logic           row_end_strobe,
  input  wire logic           int_n
);
  import dps_pkg::*;

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic                  rst_m, rst_n;
  logic                  scl_m, sda_m, strb_m, int_m;
  logic                  scl_s, sda_s, strb_s, int_s;
  logic [`DPS_QTR_W-1:0] qcnt;
  logic                  tick;

  // reset asserts at once and leaves two edges later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // pulled-up pins idle high, so the chains reset high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m, sda_m, strb_m, int_m} <= 4'hf;
      {scl_s, sda_s, strb_s, int_s} <= 4'hf;
    end else begin
      {scl_m, sda_m, strb_m, int_m} <=
        {scl_i, sda_i, row_end_strobe, int_n};
      {scl_s, sda_s, strb_s, int_s} <= {scl_m, sda_m, strb_m, int_m};
    end
  end

  // quarter bit timer; scl is made here, so no second domain
  assign tick = (qcnt == '0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) qcnt <= '0;
    else qcnt <= tick ? `DPS_QTR_W'(`DPS_QTR_CYC - 1) : qcnt - 1'b1;
  end

  // ----------------------------------------------------------------
  // transfer program
  // ----------------------------------------------------------------
  function automatic dps_item_s mk(dps_kind_e k, logic [7:0] v);
    mk = '{kind: k, val: v};
  endfunction

  // one addressed single-byte frame: start, 0x80, opcode, stop
  function automatic dps_item_s frame(logic [4:0] j, logic [7:0] opc);
    case (j)
      5'h00:   frame = mk(DPS_K_START, `DPS_NONE);
      5'h01:   frame = mk(DPS_K_SEND, `DPS_SLAVE_WR);
      5'h02:   frame = mk(DPS_K_SEND, opc);
      5'h03:   frame = mk(DPS_K_STOP, `DPS_NONE);
      default: frame = mk(DPS_K_END, `DPS_NONE);
    endcase
  endfunction

  function automatic dps_item_s prog(dps_op_e op, logic [4:0] i,
                                     dps_wire_addr_s a);
    logic [4:0] t;
    logic [7:0] opc;
    t   = (op == DPS_OP_ERASE) ? `DPS_TAIL_ERASE :
          (op == DPS_OP_WRITE) ? `DPS_TAIL_WRITE : `DPS_TAIL_READ;
    opc = (op == DPS_OP_ERASE) ? `DPS_PAGE_ERASE_OPCODE :
          (op == DPS_OP_WRITE) ? `DPS_OPC_WRITE :
                                 `DPS_OPC_READ;
    prog = mk(DPS_K_END, `DPS_NONE);
    if (i < `DPS_STEP_BODY)
      prog = frame(i, `DPS_OPC_ENTER);
    else if (i >= t)
      prog = frame(5'(i - t), `DPS_OPC_EXIT);
    else if (op == DPS_OP_ERASE && i == 5'(t - 5'h01))
      prog = mk(DPS_K_STRB, `DPS_NONE);
    else if (op == DPS_OP_ERASE && i >= `DPS_STEP_HALT)
      prog = frame(5'(i - `DPS_STEP_HALT), `DPS_OPC_HALT);
    else
      case (i)
        5'h04:   prog = mk(DPS_K_START, `DPS_NONE);
        5'h05:   prog = mk(DPS_K_SEND, `DPS_SLAVE_WR);
        5'h06:   prog = mk(DPS_K_SEND, opc);
        5'h07:   prog = mk(DPS_K_SEND, a.hi);
        5'h08:   prog = mk(DPS_K_SEND, a.lo);
        5'h09:   prog = (op == DPS_OP_ERASE) ? mk(DPS_K_STOP, `DPS_NONE) :
                        (op == DPS_OP_WRITE) ? mk(DPS_K_DATA, `DPS_NONE) :
                        mk(DPS_K_START, `DPS_NONE);
        5'h0a:   prog = (op == DPS_OP_ERASE) ? mk(DPS_K_STRB, `DPS_NONE) :
                        (op == DPS_OP_WRITE) ? mk(DPS_K_STOP, `DPS_NONE) :
                        mk(DPS_K_SEND, `DPS_SLAVE_RD);
        5'h0b:   prog = mk(DPS_K_READ, `DPS_NONE);
        default: prog = mk(DPS_K_STOP, `DPS_NONE);
      endcase
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  dps_st_e        st;
  dps_cmd_s       cmd_q;
  dps_item_s      item;
  dps_kind_e      kind_q;
  dps_wire_addr_s wa;
  logic [4:0]     idx;
  logic [11:0]    cnt, rows_m1, lim;
  logic [1:0]     q;
  logic [3:0]     bitn;
  logic [7:0]     sh;
  logic           nack, abort, qadv, ev_q3, is_tx, is_rx, is_sym;
  logic           byte_end, item_end, load, nack_end;

  assign wa        = dps_wire_addr_s'(cmd_q.addr);
  assign item      = prog(cmd_q.op, idx, wa);
  assign lim       = (idx == `DPS_STEP_CNT) ? rows_m1 : 12'h001;
  assign is_sym    = (kind_q == DPS_K_START) || (kind_q == DPS_K_STOP);
  assign is_tx     = (kind_q == DPS_K_SEND) || (kind_q == DPS_K_DATA);
  assign is_rx     = (kind_q == DPS_K_READ);
  // a released scl held low by the device freezes the bit
  assign qadv      = (st == DPS_ST_RUN) && tick && !(q == 2'h2 && !scl_s);
  assign ev_q3     = qadv && (q == 2'h3);
  assign byte_end  = ev_q3 && !is_sym && (bitn == `DPS_BIT_ACK);
  assign item_end  = (ev_q3 && is_sym) || byte_end;
  assign nack_end  = byte_end && is_tx && nack;
  assign cmd_ready = (st == DPS_ST_IDLE);
  assign busy      = (st != DPS_ST_IDLE);
  assign wr_ready  = (st == DPS_ST_FETCH) && (item.kind == DPS_K_DATA);
  assign load      = (st == DPS_ST_FETCH) &&
                     ((item.kind == DPS_K_SEND) || (wr_ready && wr_valid));
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;

  // walks the program one item at a time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st      <= DPS_ST_IDLE;
      cmd_q   <= '0;
      rows_m1 <= '0;
      idx     <= '0;
      cnt     <= '0;
      kind_q  <= DPS_K_END;
      abort   <= 1'b0;
    end else begin
      case (st)
        DPS_ST_IDLE: begin
          if (cmd_valid) begin
            cmd_q <= cmd;
            if (cmd.op == DPS_OP_ERASE) cmd_q.addr.block <= '0;
            rows_m1 <= (cmd.rows == '0) ? '0 : cmd.rows - 1'b1;
            idx   <= '0;
            cnt   <= '0;
            abort <= 1'b0;
            st    <= DPS_ST_FETCH;
          end
        end
        DPS_ST_FETCH: begin
          case (item.kind)
            DPS_K_END: st <= DPS_ST_IDLE;
            DPS_K_STRB: begin
              if (lim == '0) idx <= idx + 1'b1;
              else st <= DPS_ST_STRB_LO;
            end
            DPS_K_DATA: begin
              if (wr_valid) begin
                kind_q <= item.kind;
                st     <= DPS_ST_RUN;
              end
            end
            default: begin
              kind_q <= item.kind;
              st     <= DPS_ST_RUN;
            end
          endcase
        end
        DPS_ST_RUN: begin
          if (nack_end) begin
            kind_q <= DPS_K_STOP;
            abort  <= 1'b1;
          end else if (item_end && abort) begin
            st <= DPS_ST_IDLE;
          end else if (item_end) begin
            st <= DPS_ST_FETCH;
            // a block is eight bytes; other items take one pass
            if (is_sym || kind_q == DPS_K_SEND || cnt == `DPS_LAST_BYTE)
            begin
              idx <= idx + 1'b1;
              cnt <= '0;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
        end
        DPS_ST_STRB_LO: if (!strb_s) st <= DPS_ST_STRB_HI;
        DPS_ST_STRB_HI: begin
          if (strb_s) begin
            if (12'(cnt + 1'b1) == lim) begin
              cnt <= '0;
              idx <= idx + 1'b1;
              st  <= DPS_ST_FETCH;
            end else begin
              cnt <= cnt + 1'b1;
              st  <= DPS_ST_STRB_LO;
            end
          end
        end
        default: st <= DPS_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  // quarters: 0 set sda, 1 free scl, 2 sample once high, 3 pull scl
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      bitn   <= '0;
      sh     <= '0;
      nack   <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      if (load) sh <= (item.kind == DPS_K_DATA) ? wr_data : item.val;
      if (st != DPS_ST_RUN) begin
        q    <= '0;
        bitn <= '0;
      end else if (qadv) begin
        q <= q + 1'b1;
        case (q)
          2'h0: begin
            if (kind_q == DPS_K_START) sda_oe <= 1'b0;
            else if (kind_q == DPS_K_STOP) sda_oe <= 1'b1;
            else if (bitn != `DPS_BIT_ACK) sda_oe <= is_tx & ~sh[7];
            else sda_oe <= is_rx & (cnt != `DPS_LAST_BYTE);
          end
          2'h1: scl_oe <= 1'b0;
          2'h2: begin
            if (kind_q == DPS_K_START) sda_oe <= 1'b1;
            else if (kind_q == DPS_K_STOP) sda_oe <= 1'b0;
            else if (bitn == `DPS_BIT_ACK) nack <= sda_s;
            else if (is_rx) sh <= {sh[6:0], sda_s};
          end
          default: begin
            // a stop leaves the bus released for other masters
            if (kind_q != DPS_K_STOP) scl_oe <= 1'b1;
            if (!is_sym) begin
              bitn <= (bitn == `DPS_BIT_ACK) ? '0 : bitn + 1'b1;
              if (is_tx) sh <= {sh[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // user side results
  // ----------------------------------------------------------------
  // rsp flags clear only at accept, when no event can arrive; overflow_flag follows the synchronised int_n inverted, every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done          <= 1'b0;
      rsp           <= '0;
      rd_valid      <= 1'b0;
      rd_data       <= '0;
      rd_last       <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      done <= ((st == DPS_ST_FETCH) && (item.kind == DPS_K_END)) ||
              ((st == DPS_ST_RUN) && item_end && abort);
      rd_valid      <= byte_end && is_rx;
      overflow_flag <= !int_s;
      if (byte_end && is_rx) begin
        rd_data <= sh;
        rd_last <= (cnt == `DPS_LAST_BYTE);
      end
      if (st == DPS_ST_IDLE && cmd_valid) begin
        rsp <= '0;
      end else begin
        if (nack_end) rsp.err <= 1'b1;
        if (!int_s && busy) rsp.ovf <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic        after_start;
  logic [7:0]  byte_q, last_val;
  logic [11:0] strb_seen;

  // history that only the checks read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      after_start <= 1'b0;
      byte_q      <= '0;
      last_val    <= '0;
      strb_seen   <= '0;
    end else begin
      if (item_end && kind_q == DPS_K_START) after_start <= 1'b1;
      else if (load) after_start <= 1'b0;
      if (load) byte_q <= (item.kind == DPS_K_DATA) ? wr_data : item.val;
      if (load) last_val <= item.val;
      if (st == DPS_ST_IDLE) strb_seen <= '0;
      else if (st == DPS_ST_STRB_HI && strb_s) strb_seen <= strb_seen + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_nack;
    nack_end;
  endsequence
  sequence s_abort_stop;
    (st == DPS_ST_RUN) && (kind_q == DPS_K_STOP) && abort && scl_oe;
  endsequence

  property p_enter_first;
    (st == DPS_ST_FETCH && idx == `DPS_STEP_ENTER) |->
      item.val == `DPS_OPC_ENTER;
  endproperty
  a_enter_first: assert property (p_enter_first)
    else $error("enter digital mode byte not sent first");

  property p_addr_byte;
    (load && after_start) |->
      (item.val == `DPS_SLAVE_WR || item.val == `DPS_SLAVE_RD);
  endproperty
  a_addr_byte: assert property (p_addr_byte)
    else $error("start not followed by slave address");

  property p_nack_stop;
    s_nack |=> s_abort_stop;
  endproperty
  a_nack_stop: assert property (p_nack_stop)
    else $error("missing ack did not lead to stop");

  property p_stretch;
    (st == DPS_ST_RUN && q == 2'h2 && !scl_s) |=> (q == 2'h2);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("held scl did not stall the bit");

  property p_erase_lo;
    (load && cmd_q.op == DPS_OP_ERASE && idx == `DPS_STEP_LO) |->
      cmd_q.addr.block == '0;
  endproperty
  a_erase_lo: assert property (p_erase_lo)
    else $error("erase address carries block bits");

  property p_msb_first;
    (qadv && q == 2'h0 && is_tx && bitn != `DPS_BIT_ACK) |=>
      (sda_oe != byte_q[3'(3'h7 - bitn[2:0])]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("data bit order wrong");

  property p_strobe_count;
    (st == DPS_ST_FETCH && cmd_q.op == DPS_OP_ERASE &&
     idx == `DPS_STEP_HALT) |-> strb_seen == rows_m1;
  endproperty
  a_strobe_count: assert property (p_strobe_count)
    else $error("halt sent after wrong strobe count");

  property p_tail_wait;
    (st == DPS_ST_FETCH && cmd_q.op == DPS_OP_ERASE &&
     idx == `DPS_TAIL_ERASE) |-> strb_seen == 12'(rows_m1 + 1'b1);
  endproperty
  a_tail_wait: assert property (p_tail_wait)
    else $error("exit sent before final strobe");

  property p_exit_last;
    (st == DPS_ST_FETCH && item.kind == DPS_K_END) |->
      last_val == `DPS_OPC_EXIT;
  endproperty
  a_exit_last: assert property (p_exit_last)
    else $error("operation ended without exit byte");

endmodule // dps_host
`default_nettype wire

// >>> bench/dps_dev_model.sv
// behavioural model of the page store device on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module dps_dev_model #(
  parameter int ROW_HI = 4000,  // row body in link clocks, plain default
  parameter int ROW_LO = 16667  // strobe low time, 0.25 ms at 15 ns
) (
  input  wire logic lclk,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nack_first,
  input  wire logic stretch,
  input  wire logic raise_int,
  output logic      scl_pull,
  output logic      sda_pull,
  output logic      row_end_strobe,
  output logic      int_n
);
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [7:0]  log[$];
  logic [7:0]  fb[$];
  logic [10:0] rows_done[$];
  logic [3:0]  bitn;
  logic [7:0]  sh;
  logic [10:0] row;
  logic        in_frame;
  logic        erasing;
  logic        halt;
  int          starts;
  int          stops;
  logic [7:0]  rd_mem[8];
  logic [7:0]  rd_sh;
  logic        rd_mode;
  int          rd_cnt;

  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    row_end_strobe = 1'b1;
    in_frame = 1'b0;
    erasing = 1'b0;
    halt = 1'b0;
    bitn = 4'h0;
    starts = 0;
    stops = 0;
    rd_mode = 1'b0;
    rd_cnt = 0;
    foreach (rd_mem[i]) rd_mem[i] = 8'h00;
  end

  // interrupt stays low until the bench clears it, like a status read
  assign int_n = !raise_int;

  // start or repeated start opens a frame
  always @(negedge sda) if (scl === 1'b1) begin
    in_frame = 1'b1;
    bitn = 4'h0;
    fb.delete();
    rd_mode = 1'b0;
    starts++;
  end

  // stop closes a frame; an erase frame arms the row engine
  always @(posedge sda) if (scl === 1'b1 && in_frame) begin
    in_frame = 1'b0;
    stops++;
    if (fb.size() == 4 && fb[1] == 8'hd1 && fb[0] == 8'h80) begin
      row = {fb[2], fb[3][7:5]};
      halt = 1'b0;
      erasing = 1'b1;
      foreach (rd_mem[i]) rd_mem[i] = 8'h00;
    end else if (fb.size() > 4 && fb[1] == 8'hc9) begin
      // bytes a short block never sent stay at the erased level
      foreach (rd_mem[i])
        rd_mem[i] = (i + 4 < fb.size()) ? fb[i + 4] : 8'h00;
    end else if (fb.size() == 2 && fb[1] == 8'hc0 && erasing) begin
      halt = 1'b1;
    end
  end

  // shift in bits msb first, the ninth clock is the acknowledge
  always @(posedge scl) if (in_frame) begin
    if (bitn < 4'h8) begin
      sh = {sh[6:0], sda};
      bitn = bitn + 4'h1;
    end else begin
      bitn = 4'h0;
      if (rd_mode && sda) rd_mode = 1'b0;
    end
  end

  // acknowledge on the falling clock; optional stall after every byte taken;
  // in a read the stored block goes out here, the master answers each
  always @(negedge scl) if (in_frame) begin
    sda_pull = 1'b0;
    if (bitn == 4'h8 && !rd_mode) begin
      log.push_back(sh);
      fb.push_back(sh);
      sda_pull = !(nack_first && log.size() == 1);
      if (sh == 8'h81 && fb.size() == 1) begin
        rd_mode = 1'b1;
        rd_cnt = 0;
      end
      if (stretch) begin
        scl_pull = 1'b1;
        repeat (100) @(posedge lclk);
        scl_pull = 1'b0;
      end
    end else if (rd_mode && bitn == 4'h0) begin
      rd_sh = rd_mem[rd_cnt % 8];
      rd_cnt = rd_cnt + 1;
      sda_pull = !rd_sh[7];
    end else if (rd_mode && bitn < 4'h8) begin
      sda_pull = !rd_sh[4'h7 - bitn];
    end
  end

  // ----------------------------------------------------------------
  // row engine: bus untouched while rows erase
  // ----------------------------------------------------------------
  always begin
    @(posedge lclk);
    if (erasing) begin
      repeat (ROW_HI) @(posedge lclk);
      row_end_strobe = 1'b0;
      rows_done.push_back(row);
      repeat (ROW_LO) @(posedge lclk);
      row_end_strobe = 1'b1;
      row = row + 11'h001;
      if (halt) erasing = 1'b0;
    end
  end
endmodule // dps_dev_model
`default_nettype wire

// >>> bench/dps_host_test.sv
// self-checking bench for the digital page store host
`timescale 1ns/1ps
`default_nettype none
module dps_host_test;
  import dps_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic       clk, lclk, rst_b, cmd_valid, wr_valid;
  logic       nack_first, stretch, raise_int;
  logic       cmd_ready, wr_ready, rd_valid, rd_last, done, busy;
  logic       overflow_flag, scl_o, scl_oe, sda_o, sda_oe;
  logic       scl_pull, sda_pull, row_end_strobe, int_n;
  logic       scl_w, sda_w;
  logic [7:0] wr_data, rd_data;
  logic [7:0] wd[8];
  dps_cmd_s   cmd;
  dps_rsp_s   rsp, seen_rsp;
  int         num_errors, num_checks;
  int         num_rd;

  // open-drain wires with pull-ups
  assign scl_w = (scl_oe ? scl_o : 1'b1) & !scl_pull;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & !sda_pull;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // link clock, unrelated in phase
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #7.5 lclk = ~lclk;
  end

  dps_host i_dut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_last(rd_last), .done(done), .rsp(rsp),
    .busy(busy), .overflow_flag(overflow_flag), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .row_end_strobe(row_end_strobe), .int_n(int_n));

  // short rows keep the erase run small
  dps_dev_model #(.ROW_HI(2000), .ROW_LO(40)) i_dev (.lclk(lclk),
    .scl(scl_w), .sda(sda_w), .nack_first(nack_first),
    .stretch(stretch), .raise_int(raise_int), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .row_end_strobe(row_end_strobe),
    .int_n(int_n));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // compare every byte the device saw, then wipe its log
  task automatic check_log(input logic [7:0] exp[$]);
    check("byte count", i_dev.log.size(), exp.size());
    foreach (exp[i]) begin
      if (i < i_dev.log.size()) check("bus byte", i_dev.log[i], exp[i]);
    end
    i_dev.log.delete();
  endtask

  // one operation: offer, feed write bytes, wait for done (bounded)
  task automatic run_op(input dps_op_e op, input logic [10:0] page,
                        input logic [4:0] blk, input logic [11:0] rows);
    int  n, k;
    logic tk, dn;
    n = 0;
    k = 0;
    dn = 1'b0;
    num_rd = 0;
    i_dev.starts = 0;
    i_dev.stops = 0;
    @(posedge clk);
    cmd <= '{op: op, addr: '{page: page, block: blk}, rows: rows};
    cmd_valid <= 1'b1;
    wr_data <= wd[0];
    wr_valid <= (op == DPS_OP_WRITE);
    @(negedge clk);
    check("cmd_ready", cmd_ready, 1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    check("busy", busy, 1);
    while (!dn && n < 100000) begin
      if (rd_valid) begin
        check("rd_data", rd_data, wd[num_rd[2:0]]);
        check("rd_last", rd_last, num_rd == 7);
        num_rd++;
      end
      tk = wr_valid & wr_ready;
      dn = done;
      if (dn) seen_rsp = rsp;
      @(posedge clk);
      n++;
      if (tk) begin
        k++;
        wr_data <= wd[k[2:0]];
        wr_valid <= (k < 8);
      end
      @(negedge clk);
    end
    if (!dn) begin
      check("done", dn, 1);
      conclude();
    end
    check("busy", busy, 0);
    check("write bytes", k, (op == DPS_OP_WRITE) ? 8 : 0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // full block write with the device stalling after every byte
  task automatic sc_write;
    logic [10:0] pg;
    logic [4:0]  bk;
    pg = 11'h5a3;
    bk = 5'h13;
    wd = '{8'ha5, 8'h3c, 8'h81, 8'h7e, 8'h00, 8'hff, 8'h12, 8'hc6};
    stretch = 1'b1;
    run_op(DPS_OP_WRITE, pg, bk, 12'h001);
    stretch = 1'b0;
    check("rsp", seen_rsp, 2'b00);
    check("frames", i_dev.stops, 3);
    check_log('{8'h80, 8'hc0, 8'h80, 8'hc9, pg[10:3], {pg[2:0], bk},
      wd[0], wd[1], wd[2], wd[3], wd[4], wd[5], wd[6], wd[7],
      8'h80, 8'h40});
  endtask

  // read back the block just written; seven acks, then a nack
  task automatic sc_read;
    run_op(DPS_OP_READ, 11'h5a3, 5'h13, 12'h001);
    check("rsp", seen_rsp, 2'b00);
    check("read bytes", num_rd, 8);
    check("starts", i_dev.starts, 4);
    check("frames", i_dev.stops, 3);
    check_log('{8'h80, 8'hc0, 8'h80, 8'he1, 8'hb4, 8'h73, 8'h81,
      8'h80, 8'h40});
  endtask

  // two-row erase from a non-zero block field
  task automatic sc_erase;
    logic [10:0] pg;
    pg = 11'h0c4;
    run_op(DPS_OP_ERASE, pg, 5'h1f, 12'h002);
    check("rsp", seen_rsp, 2'b00);
    check_log('{8'h80, 8'hc0, 8'h80, 8'hd1, pg[10:3], {pg[2:0], 5'h00},
      8'h80, 8'hc0, 8'h80, 8'h40});
    check("rows erased", i_dev.rows_done.size(), 2);
    check("first row", i_dev.rows_done[0], pg);
    check("strobe idle", row_end_strobe, 1);
  endtask

  // refused address byte with the interrupt line low
  task automatic sc_nack;
    nack_first = 1'b1;
    raise_int = 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("overflow_flag", overflow_flag, 1);
    run_op(DPS_OP_READ, 11'h010, 5'h02, 12'h001);
    nack_first = 1'b0;
    raise_int = 1'b0;
    check("rsp", seen_rsp, 2'b11);
    check("frames", i_dev.stops, 1);
    check("read bytes", num_rd, 0);
    check_log('{8'h80});
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("overflow_flag", overflow_flag, 0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    num_checks = 0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    nack_first = 1'b0;
    stretch = 1'b0;
    raise_int = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("reset sda_oe", sda_oe, 0);
    check("reset scl_oe", scl_oe, 0);
    sc_write();
    sc_read();
    sc_erase();
    sc_nack();
    conclude();
  end
endmodule // dps_host_test
`default_nettype wire
